//--- mic_irq_ctrl.sv
`timescale 1ns/100ps
`include "mic_defs.svh"

// Summary of operation
// - Control bit 0 is the master enable; clear blocks all servicing.
// - Control bit 1 enables the USB request source.
// - Control bits 2 and 3 enable the two timer request sources.
// - Control bit 4 sets on endpoint access, suspend, resume or bus reset.
// - Control bit 5 sets on first timer overflow.
// - Control bit 6 sets on second timer overflow.
// - Control bit 7 always reads as zero.
// - USB service calls vector 04H, clears its flag and master enable.
// - First timer service calls 08H, clears its flag and master enable.
// - Second timer service calls 0CH, clears its flag and master enable.
// - Stack full withholds service and keeps the flag until a return.
// - Acknowledge pushes only the program counter.
// - During service new requests only latch; nesting needs re-enabling.
// - Return from interrupt sets master enable; plain return does not.
// - Requests latch on any clock; service starts only at a phase pulse.
// - Priority: USB, then first timer, then second timer.
// - Flags stay set until serviced or cleared by software.
// - Endpoint access sets its status bit; firmware clears it.
// - Suspend sets status bit 0 and raises the USB request.
// - Resume sets status bit 3 and raises the USB request.
// - Any request wakes the processor from power-down.
// - Stack is full with all eight levels in use.
module mic_irq_ctrl
  import mic_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    phase_two_pulse,
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic [`MIC_EP_COUNT-1:0] ep_access,
  input  wire logic                    usb_suspend,
  input  wire logic                    usb_resume,
  input  wire logic                    usb_bus_reset,
  input  wire logic                    timer0_ovf,
  input  wire logic                    timer1_ovf,
  input  wire logic                    call_push,
  input  wire logic                    plain_return,
  input  wire logic                    return_from_irq,
  input  wire logic                    halted,
  output logic                         irq_call,
  output logic      [11:0]             irq_vector,
  output logic                         irq_push_pc,
  output logic                         wake_up,
  output logic      [3:0]              stack_pointer
);
  import mic_pkg::*;

  // ---------------------------------------------------------------
  // Control register and event flags
  // ---------------------------------------------------------------
  logic                      master_irq_enable_r;
  logic                      usb_irq_enable_r;
  logic                      timer0_irq_enable_r;
  logic                      timer1_irq_enable_r;
  logic                      usb_irq_flag_r;
  logic                      timer0_irq_flag_r;
  logic                      timer1_irq_flag_r;
  logic [`MIC_EP_COUNT-1:0]  endpoint_irq_status_r;
  logic                      suspend_r;
  logic                      resume_r;
  logic [3:0]                sp_r;
  logic                      usb_event;
  logic                      stack_full;
  logic                      ack;
  logic                      any_ret;
  logic                      wr_ctrl;
  logic                      wr_ep;
  logic                      wr_usc;
  mic_src_t                  src;

  assign usb_event  = (|ep_access) | usb_suspend | usb_resume | usb_bus_reset;
  assign stack_full = (sp_r == `MIC_STACK_DEPTH);
  assign any_ret    = plain_return | return_from_irq;
  assign wr_ctrl    = reg_wr && (reg_addr == `MIC_IRQ_CTRL_ADDR);
  assign wr_ep      = reg_wr && (reg_addr == `MIC_EP_STAT_ADDR);
  assign wr_usc     = reg_wr && (reg_addr == `MIC_USB_CS_ADDR);

  // Priority resolve among enabled pending sources.
  always_comb begin
    src = MIC_SRC_NONE;
    if (usb_irq_flag_r && usb_irq_enable_r) begin
      src = MIC_SRC_USB;
    end else if (timer0_irq_flag_r && timer0_irq_enable_r) begin
      src = MIC_SRC_T0;
    end else if (timer1_irq_flag_r && timer1_irq_enable_r) begin
      src = MIC_SRC_T1;
    end
  end

  // Acknowledge only on a phase pulse, master enabled, stack not full.
  assign ack = phase_two_pulse && master_irq_enable_r && !stack_full
               && (src != MIC_SRC_NONE) && !call_push && !any_ret;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      master_irq_enable_r <= 1'b0;
    end else if (ack) begin
      master_irq_enable_r <= 1'b0;
    end else if (return_from_irq) begin
      master_irq_enable_r <= 1'b1;
    end else if (wr_ctrl) begin
      master_irq_enable_r <= reg_wdata[`MIC_BIT_MASTER_EN];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      usb_irq_enable_r    <= 1'b0;
      timer0_irq_enable_r <= 1'b0;
      timer1_irq_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      usb_irq_enable_r    <= reg_wdata[`MIC_BIT_USB_EN];
      timer0_irq_enable_r <= reg_wdata[`MIC_BIT_T0_EN];
      timer1_irq_enable_r <= reg_wdata[`MIC_BIT_T1_EN];
    end
  end

  // Set wins over software clear and over service clear.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      usb_irq_flag_r <= 1'b0;
    end else if (usb_event) begin
      usb_irq_flag_r <= 1'b1;
    end else if (ack && src == MIC_SRC_USB) begin
      usb_irq_flag_r <= 1'b0;
    end else if (wr_ctrl) begin
      usb_irq_flag_r <= reg_wdata[`MIC_BIT_USB_FLAG];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timer0_irq_flag_r <= 1'b0;
    end else if (timer0_ovf) begin
      timer0_irq_flag_r <= 1'b1;
    end else if (ack && src == MIC_SRC_T0) begin
      timer0_irq_flag_r <= 1'b0;
    end else if (wr_ctrl) begin
      timer0_irq_flag_r <= reg_wdata[`MIC_BIT_T0_FLAG];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timer1_irq_flag_r <= 1'b0;
    end else if (timer1_ovf) begin
      timer1_irq_flag_r <= 1'b1;
    end else if (ack && src == MIC_SRC_T1) begin
      timer1_irq_flag_r <= 1'b0;
    end else if (wr_ctrl) begin
      timer1_irq_flag_r <= reg_wdata[`MIC_BIT_T1_FLAG];
    end
  end

  // ---------------------------------------------------------------
  // Endpoint status and suspend/resume indications
  // ---------------------------------------------------------------
  // Writing a 0 to a bit clears it; a new access in the same cycle wins.
  genvar gi;
  generate
    for (gi = 0; gi < `MIC_EP_COUNT; gi++) begin : g_ep
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          endpoint_irq_status_r[gi] <= 1'b0;
        end else if (ep_access[gi]) begin
          endpoint_irq_status_r[gi] <= 1'b1;
        end else if (wr_ep && !reg_wdata[gi]) begin
          endpoint_irq_status_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      suspend_r <= 1'b0;
      resume_r  <= 1'b0;
    end else begin
      if (usb_suspend) begin
        suspend_r <= 1'b1;
      end else if (wr_usc && !reg_wdata[`MIC_BIT_SUSPEND]) begin
        suspend_r <= 1'b0;
      end
      if (usb_resume) begin
        resume_r <= 1'b1;
      end else if (wr_usc && !reg_wdata[`MIC_BIT_RESUME]) begin
        resume_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Stack pointer tracking
  // ---------------------------------------------------------------
  // An ordinary call on a full stack leaves the pointer held at eight.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sp_r <= `MIC_SP_ZERO;
    end else if (any_ret && sp_r != `MIC_SP_ZERO) begin
      sp_r <= sp_r - `MIC_SP_ONE;
    end else if ((ack || call_push) && !stack_full) begin
      sp_r <= sp_r + `MIC_SP_ONE;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_call    <= 1'b0;
      irq_push_pc <= 1'b0;
      irq_vector  <= `MIC_VEC_USB;
    end else begin
      irq_call    <= ack;
      irq_push_pc <= ack;
      if (ack) begin
        unique case (src)
          MIC_SRC_USB: irq_vector <= `MIC_VEC_USB;
          MIC_SRC_T0:  irq_vector <= `MIC_VEC_T0;
          MIC_SRC_T1:  irq_vector <= `MIC_VEC_T1;
          MIC_SRC_NONE: irq_vector <= irq_vector;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= halted && (usb_event | timer0_ovf | timer1_ovf);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stack_pointer <= `MIC_SP_ZERO;
    end else begin
      stack_pointer <= sp_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `MIC_IRQ_CTRL_ADDR: reg_rdata <= {1'b0, timer1_irq_flag_r, timer0_irq_flag_r,
                                          usb_irq_flag_r, timer1_irq_enable_r,
                                          timer0_irq_enable_r, usb_irq_enable_r,
                                          master_irq_enable_r};
        `MIC_EP_STAT_ADDR:  reg_rdata <= {4'h0, endpoint_irq_status_r};
        `MIC_USB_CS_ADDR:   reg_rdata <= {4'h0, resume_r, 2'h0, suspend_r};
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_full_block;
    @(posedge ref_clk) disable iff (!rst_n) stack_full |=> !irq_call;
  endproperty
  a_full_block: assert property (p_full_block) else $error("call while stack full");

  property p_ack_clears_master;
    @(posedge ref_clk) disable iff (!rst_n)
      (ack && !return_from_irq) |=> !master_irq_enable_r && irq_call;
  endproperty
  a_ack_clears_master: assert property (p_ack_clears_master) else $error("master kept");

  property p_usb_vec;
    @(posedge ref_clk) disable iff (!rst_n)
      (ack && usb_irq_flag_r && usb_irq_enable_r) |=> irq_vector == `MIC_VEC_USB;
  endproperty
  a_usb_vec: assert property (p_usb_vec) else $error("usb vector wrong");

  property p_t0_vec;
    @(posedge ref_clk) disable iff (!rst_n)
      (ack && !(usb_irq_flag_r && usb_irq_enable_r) && timer0_irq_flag_r
       && timer0_irq_enable_r) |=> irq_vector == `MIC_VEC_T0;
  endproperty
  a_t0_vec: assert property (p_t0_vec) else $error("timer0 vector wrong");

  property p_no_master;
    @(posedge ref_clk) disable iff (!rst_n) !master_irq_enable_r |=> !irq_call;
  endproperty
  a_no_master: assert property (p_no_master) else $error("call with master off");

  property p_phase_only;
    @(posedge ref_clk) disable iff (!rst_n) !phase_two_pulse |=> !irq_call;
  endproperty
  a_phase_only: assert property (p_phase_only) else $error("call off phase");

  property p_t1_sets;
    @(posedge ref_clk) disable iff (!rst_n) timer1_ovf |=> timer1_irq_flag_r;
  endproperty
  a_t1_sets: assert property (p_t1_sets) else $error("timer1 flag not set");

  property p_return_from_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (return_from_irq && !ack) |=> master_irq_enable_r;
  endproperty
  a_return_from_irq: assert property (p_return_from_irq) else $error("return_from_irq left master clear");

  property p_usb_sets;
    @(posedge ref_clk) disable iff (!rst_n) usb_event |=> usb_irq_flag_r ##1 1'b1;
  endproperty
  a_usb_sets: assert property (p_usb_sets) else $error("usb flag not set");

endmodule : mic_irq_ctrl

//--- mic_defs.svh
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH

// ---------------------------------------------------------------
// Register map and bit positions
// ---------------------------------------------------------------
`define MIC_IRQ_CTRL_ADDR   8'h0b
`define MIC_EP_STAT_ADDR    8'h1b
`define MIC_USB_CS_ADDR     8'h1a
`define MIC_BIT_MASTER_EN   0
`define MIC_BIT_USB_EN      1
`define MIC_BIT_T0_EN       2
`define MIC_BIT_T1_EN       3
`define MIC_BIT_USB_FLAG    4
`define MIC_BIT_T0_FLAG     5
`define MIC_BIT_T1_FLAG     6
`define MIC_BIT_SUSPEND     0
`define MIC_BIT_RESUME      3
`define MIC_CTRL_RESET      8'h00
`define MIC_VEC_USB         12'h004
`define MIC_VEC_T0          12'h008
`define MIC_VEC_T1          12'h00c
`define MIC_STACK_DEPTH     4'h8
`define MIC_SP_ZERO         4'h0
`define MIC_SP_ONE          4'h1
`define MIC_EP_COUNT        4

`endif

//--- mic_pkg.sv
package mic_pkg;
  typedef enum logic [1:0] {
    MIC_SRC_NONE,
    MIC_SRC_USB,
    MIC_SRC_T0,
    MIC_SRC_T1
  } mic_src_t;
endpackage : mic_pkg

//--- mic_core_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Core sequencer model: one phase pulse per instruction cycle
// ------------------------------------------------------------
module mic_core_model #(
  parameter int PERIOD = 4
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  output logic      phase_two_pulse
);
  int cnt_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r           <= 0;
      phase_two_pulse <= 1'b0;
    end else begin
      cnt_r           <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      phase_two_pulse <= (cnt_r == PERIOD - 1);
    end
  end
endmodule : mic_core_model

//--- mcu_interrupt_controller_tb_top.sv
`timescale 1ns/100ps
`include "mic_defs.svh"
module mcu_interrupt_controller_tb_top;
  typedef struct packed {int code; logic [7:0] en; logic [7:0] flag; logic [11:0] vec;} mic_row_t;
  localparam logic [7:0] ctrl_a = `MIC_IRQ_CTRL_ADDR;
  localparam logic [7:0] cs_a   = `MIC_USB_CS_ADDR;
  localparam logic [7:0] ep_a   = `MIC_EP_STAT_ADDR;
  logic        ref_clk, rst_n, p2, reg_wr, reg_rd, usb_suspend, usb_resume, usb_bus_reset;
  logic        timer0_ovf, timer1_ovf, call_push, plain_return, return_from_irq, halted;
  logic        irq_call, irq_push_pc, wake_up, wk;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  ep_access, stack_pointer;
  logic [11:0] irq_vector;
  int          errors, checks, cyc;
  mic_row_t    rows[6] = '{'{0, 8'h03, 8'h10, 12'h004}, '{1, 8'h03, 8'h10, 12'h004},
                           '{2, 8'h03, 8'h10, 12'h004}, '{3, 8'h03, 8'h10, 12'h004},
                           '{4, 8'h05, 8'h20, 12'h008}, '{5, 8'h09, 8'h40, 12'h00c}};
  logic [7:0]  blk[5] = '{8'h12, 8'h11, 8'h21, 8'h41, 8'hfe};
  logic [11:0] pv[3]  = '{12'h004, 12'h008, 12'h00c};
  logic [7:0]  pr[3]  = '{8'h6e, 8'h4e, 8'h0e};

  mic_core_model #(.PERIOD(4)) i_core (.ref_clk(ref_clk), .rst_n(rst_n), .phase_two_pulse(p2));

  mic_irq_ctrl i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .phase_two_pulse(p2), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ep_access(ep_access), .usb_suspend(usb_suspend), .usb_resume(usb_resume),
    .usb_bus_reset(usb_bus_reset), .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf),
    .call_push(call_push), .plain_return(plain_return), .return_from_irq(return_from_irq),
    .halted(halted), .irq_call(irq_call), .irq_vector(irq_vector),
    .irq_push_pc(irq_push_pc), .wake_up(wake_up), .stack_pointer(stack_pointer)
  );

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task close_out;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("rdata", {4'h0, reg_rdata}, {4'h0, e});
    @(posedge ref_clk);
  endtask : rd

  task pulse(input int code);
    case (code)
      0: usb_suspend <= 1'b1;
      1: usb_resume <= 1'b1;
      2: usb_bus_reset <= 1'b1;
      3: ep_access <= 4'h4;
      4: timer0_ovf <= 1'b1;
      5: timer1_ovf <= 1'b1;
      6: call_push <= 1'b1;
      7: plain_return <= 1'b1;
      default: return_from_irq <= 1'b1;
    endcase
    @(posedge ref_clk);
    {usb_suspend, usb_resume, usb_bus_reset, timer0_ovf, timer1_ovf} <= '0;
    {call_push, plain_return, return_from_irq, ep_access} <= '0;
    @(negedge ref_clk);
    wk = wake_up;
    @(posedge ref_clk);
  endtask : pulse

  task wcall(input logic [11:0] v);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (irq_call !== 1'b1 && n < 6) begin
      @(negedge ref_clk);
      n++;
    end
    chk("call", {10'h0, irq_call, irq_push_pc}, 12'h003);
    chk("vector", irq_vector, v);
    @(posedge ref_clk);
  endtask : wcall

  task quiet;
    int n;
    n = 0;
    repeat (16) begin
      @(negedge ref_clk);
      if (irq_call !== 1'b0) n++;
    end
    chk("quiet", n[11:0], 12'h000);
    @(posedge ref_clk);
  endtask : quiet

  task stk(input logic [3:0] e);
    @(negedge ref_clk);
    chk("stack", {8'h0, stack_pointer}, {8'h0, e});
    @(posedge ref_clk);
  endtask : stk

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    cyc = 0;
    forever @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
        errors++;
        close_out;
      end
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, ep_access, halted} = '0;
    {usb_suspend, usb_resume, usb_bus_reset, timer0_ovf, timer1_ovf} = '0;
    {call_push, plain_return, return_from_irq} = '0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ctrl_a, 8'h00);
    rd(8'h1f, 8'h00);
    stk(4'h0);
    for (int i = 0; i < 6; i++) begin
      wr(ctrl_a, 8'h00);
      halted <= (i == 5);
      pulse(rows[i].code);
      halted <= 1'b0;
      chk("wake", {11'h0, wk}, {11'h0, i == 5});
      rd(ctrl_a, rows[i].flag);
      wr(ctrl_a, rows[i].flag | rows[i].en);
      wcall(rows[i].vec);
      rd(ctrl_a, rows[i].en & 8'hfe);
      pulse(8);
      stk(4'h0);
    end
    rd(cs_a, 8'h09);
    rd(ep_a, 8'h04);
    wr(cs_a, 8'h00);
    wr(ep_a, 8'h00);
    rd(cs_a, 8'h00);
    rd(ep_a, 8'h00);
    foreach (blk[i]) begin
      wr(ctrl_a, blk[i]);
      quiet();
      rd(ctrl_a, blk[i] & 8'h7f);
    end
    wr(ctrl_a, 8'h7f);
    for (int i = 0; i < 3; i++) begin
      wcall(pv[i]);
      rd(ctrl_a, pr[i]);
      quiet();
      pulse(8);
    end
    wr(ctrl_a, 8'h00);
    // Calls are issued only outside service routines.
    repeat (8) pulse(6);
    stk(4'h8);
    wr(ctrl_a, 8'h13);
    quiet();
    rd(ctrl_a, 8'h13);
    pulse(7);
    wcall(12'h004);
    pulse(7);
    rd(ctrl_a, 8'h02);
    pulse(8);
    rd(ctrl_a, 8'h03);
    stk(4'h6);
    wr(ctrl_a, 8'h7e);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ctrl_a, 8'h00);
    stk(4'h0);
    close_out;
  end
endmodule : mcu_interrupt_controller_tb_top
